// [core/config_pin_interface.v]
// How it works
// - Passive schemes take data on each rising edge of config_clock.
// - Active serial: device drives config_clock to time memory reads.
// - Active serial: memory_select_n low while data is read out.
// - After active serial load config_clock goes inactive, then user I/O.
// - Passive schemes never hand config_clock to user I/O.
// - Toggling config_clock after configuration is ignored.
// - After passive load serial_cfg_in becomes user I/O per dual setting.
// - Serial schemes keep seven upper data pins tri-stated while loading.
// - Disabled optional pins stay tri-stated with pull-ups while loading.
// - Enabled startup_clock_in paces the initialization sequence.
// - Init-done output released during reconfigure and loading start.
// - Init-done released when initialization ends; user mode entered.
// - Enabled global_output_enable low tri-states every user pin.
// - Enabled global_clear_n low clears every user register.
// - load_complete held low while loading, released after all data.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "config_pin_map.vh"
module config_pin_interface #(
  parameter LEN_WIDTH = 24,
  parameter [15:0] INIT_COUNT = `INIT_CYCLES,
  parameter [7:0] AS_HALF = `AS_HALF_PERIOD
) (
  input wire clk_sys,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire configClockIn,
  output reg configClockOut,
  output reg configClockOe,
  input wire [7:0] dataIn,
  output reg [7:0] dataOut,
  output reg [7:0] dataOe,
  output reg memorySelectN,
  input wire chipEnableN,
  input wire reconfigureRequestN,
  input wire startupClockIn,
  input wire globalOutputEnable,
  input wire globalClearN,
  input wire loadCompleteIn,
  output reg loadCompleteOe,
  output reg initDoneOe,
  output reg optPullupEn,
  output reg [7:0] cfgByte,
  output reg cfgByteValid,
  output reg userMode,
  output reg userClearN,
  input wire [7:0] userDataOut,
  input wire [7:0] userDataOe,
  input wire userClockOut,
  input wire userClockOe
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_INIT = 2'h2;
  localparam [1:0] ST_USER = 2'h3;
  localparam [LEN_WIDTH-1:0] LEN_ONE = {{(LEN_WIDTH-1){1'b0}}, 1'b1};

  function rise;
    input prev;
    input cur;
    begin
      rise = cur & ~prev;
    end
  endfunction

  reg [14:0] syncA_r;
  reg [14:0] syncB_r;
  reg clkPrev_r;
  reg suPrev_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] ctrl_r;
  reg [LEN_WIDTH-1:0] len_r;
  reg [LEN_WIDTH-1:0] count_r;
  reg [7:0] last_r;
  reg [3:0] opt_r;
  reg optValid_r;
  reg [7:0] shift_r;
  reg [2:0] bitCnt_r;
  reg [7:0] divCnt_r;
  reg asClk_r;
  reg [15:0] initCnt_r;
  reg [7:0] byteNow;
  reg byteDone;
  wire cfgClkS;
  wire [7:0] dataS;
  wire ceNS;
  wire reqNS;
  wire suClkS;
  wire goeS;
  wire gclrNS;
  wire ldS;
  wire [1:0] mode;
  wire isAs;
  wire passiveEdge;
  wire asEdge;
  wire sampleEdge;
  wire initTick;
  wire lastByte;
  wire oeAllowed;
  wire apbWrite;
  wire hit;

  // Two-flop synchroniser for every pin input
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_r <= 15'h7fff;
      syncB_r <= 15'h7fff;
    end
    else
    begin
      syncA_r <= {configClockIn, dataIn, chipEnableN, reconfigureRequestN,
                  startupClockIn, globalOutputEnable, globalClearN,
                  loadCompleteIn};
      syncB_r <= syncA_r;
    end
  end

  assign cfgClkS = syncB_r[14];
  assign dataS = syncB_r[13:6];
  assign ceNS = syncB_r[5];
  assign reqNS = syncB_r[4];
  assign suClkS = syncB_r[3];
  assign goeS = syncB_r[2];
  assign gclrNS = syncB_r[1];
  assign ldS = syncB_r[0];
  assign mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign isAs = (mode == `MODE_ACTIVE_SERIAL);

  // Edge history of the sampled clocks
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkPrev_r <= 1'b1;
      suPrev_r <= 1'b1;
    end
    else
    begin
      clkPrev_r <= cfgClkS;
      suPrev_r <= suClkS;
    end
  end

  // Config clock edges only count while loading
  assign passiveEdge = !isAs && (state_r == ST_LOAD) &&
                       rise(clkPrev_r, cfgClkS);
  assign asEdge = isAs && (state_r == ST_LOAD) && !asClk_r &&
                  (divCnt_r == AS_HALF - 8'h01);
  assign sampleEdge = passiveEdge | asEdge;
  assign initTick = opt_r[`OPT_STARTUP_CLOCK] ?
                    rise(suPrev_r, suClkS) : 1'b1;
  assign lastByte = (count_r + LEN_ONE == len_r);

  // Divider making the active serial clock
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_r <= 8'h00;
      asClk_r <= 1'b0;
    end
    else if (isAs && state_r == ST_LOAD)
    begin
      if (divCnt_r == AS_HALF - 8'h01)
      begin
        divCnt_r <= 8'h00;
        asClk_r <= ~asClk_r;
      end
      else
        divCnt_r <= divCnt_r + 8'h01;
    end
    else
    begin
      divCnt_r <= 8'h00;
      asClk_r <= 1'b0;
    end
  end

  // Byte assembly: serial LSB first, or whole byte in parallel
  always @*
  begin
    byteDone = 1'b0;
    byteNow = shift_r;
    if (sampleEdge)
    begin
      if (mode == `MODE_FAST_PASSIVE_PARALLEL)
      begin
        byteDone = 1'b1;
        byteNow = dataS;
      end
      else
      begin
        byteNow = {dataS[0], shift_r[7:1]};
        byteDone = (bitCnt_r == 3'h7);
      end
    end
  end

  // Serial shifter and byte counter
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_r <= 8'h00;
      bitCnt_r <= 3'h0;
      count_r <= {LEN_WIDTH{1'b0}};
      last_r <= 8'h00;
      cfgByte <= 8'h00;
      cfgByteValid <= 1'b0;
      opt_r <= 4'h0;
      optValid_r <= 1'b0;
    end
    else
    begin
      cfgByteValid <= byteDone;
      if (state_r == ST_IDLE)
      begin
        bitCnt_r <= 3'h0;
        count_r <= {LEN_WIDTH{1'b0}};
        opt_r <= 4'h0;
        optValid_r <= 1'b0;
      end
      else if (sampleEdge)
      begin
        shift_r <= byteNow;
        bitCnt_r <= bitCnt_r + 3'h1;
        if (byteDone)
        begin
          count_r <= count_r + LEN_ONE;
          last_r <= byteNow;
          cfgByte <= byteNow;
          if (!optValid_r)
          begin
            opt_r <= byteNow[3:0];
            optValid_r <= 1'b1;
          end
        end
      end
    end
  end

  // Load, initialise, run
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (reqNS && !ceNS)
          state_nxt = ST_LOAD;
      ST_LOAD:
        if (byteDone && lastByte)
          state_nxt = ST_INIT;
      ST_INIT:
        if (ldS && initTick && initCnt_r == INIT_COUNT - 16'h0001)
          state_nxt = ST_USER;
      ST_USER:
        state_nxt = ST_USER;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (!reqNS || (ceNS && state_r == ST_LOAD))
      state_nxt = ST_IDLE;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      initCnt_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != ST_INIT)
        initCnt_r <= 16'h0000;
      else if (ldS && initTick)
        initCnt_r <= initCnt_r + 16'h0001;
    end
  end

  // Global overrides, each gated by its loaded option
  assign oeAllowed = !(opt_r[`OPT_GLOBAL_OE] && !goeS);

  // Pin drivers
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      configClockOut <= 1'b0;
      configClockOe <= 1'b0;
      memorySelectN <= 1'b1;
      dataOut <= 8'h00;
      dataOe <= 8'h00;
      loadCompleteOe <= 1'b1;
      initDoneOe <= 1'b0;
      optPullupEn <= 1'b1;
      userMode <= 1'b0;
      userClearN <= 1'b0;
    end
    else
    begin
      userMode <= (state_r == ST_USER);
      optPullupEn <= (state_r != ST_USER);
      loadCompleteOe <= (state_r == ST_IDLE) ||
                        (state_r == ST_LOAD);
      initDoneOe <= optValid_r && opt_r[`OPT_INIT_DONE] &&
                    (state_r == ST_LOAD || state_r == ST_INIT);
      userClearN <= (state_r == ST_USER) &&
                    !(opt_r[`OPT_GLOBAL_CLEAR] && !gclrNS);
      memorySelectN <= !(isAs && state_r == ST_LOAD);
      if (isAs && state_r != ST_USER)
      begin
        configClockOut <= asClk_r;
        configClockOe <= (state_r != ST_IDLE);
      end
      else if (isAs)
      begin
        configClockOut <= userClockOut;
        configClockOe <= userClockOe && oeAllowed;
      end
      else
      begin
        configClockOut <= 1'b0;
        configClockOe <= 1'b0;
      end
      if (state_r == ST_USER && ctrl_r[`CTRL_DUAL_BIT] && oeAllowed)
      begin
        dataOut <= userDataOut;
        dataOe <= isAs ? {userDataOe[7:1], 1'b0} : userDataOe;
      end
      else
      begin
        dataOut <= 8'h00;
        dataOe <= 8'h00;
      end
    end
  end

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign apbWrite = psel && penable && pwrite;
  assign hit = (paddr == `REG_CTRL) || (paddr == `REG_LEN) ||
               (paddr == `REG_STATUS) || (paddr == `REG_COUNT) ||
               (paddr == `REG_LAST);
  assign pslverr = psel && penable && !hit;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `CTRL_RESET;
      len_r <= `LEN_RESET;
    end
    else if (apbWrite)
    begin
      if (paddr == `REG_CTRL)
        ctrl_r <= pwdata[2:0];
      if (paddr == `REG_LEN)
        len_r <= pwdata[LEN_WIDTH-1:0];
    end
  end

  // Read mux
  always @*
  begin
    prdata = 32'h00000000;
    case (paddr)
      `REG_CTRL:
        prdata[2:0] = ctrl_r;
      `REG_LEN:
        prdata[LEN_WIDTH-1:0] = len_r;
      `REG_STATUS:
        prdata[9:0] = {optValid_r, ldS, opt_r, 2'h0, state_r};
      `REG_COUNT:
        prdata[LEN_WIDTH-1:0] = count_r;
      `REG_LAST:
        prdata[7:0] = last_r;
      default:
        prdata = 32'h00000000;
    endcase
  end
endmodule // config_pin_interface

// [shared/config_pin_map.vh]
`ifndef CONFIG_PIN_MAP_VH
`define CONFIG_PIN_MAP_VH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_LEN 8'h04
`define REG_STATUS 8'h08
`define REG_COUNT 8'h0c
`define REG_LAST 8'h10
// Control field positions and reset values
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_DUAL_BIT 2
`define CTRL_RESET 3'h0
`define LEN_RESET 24'h000010
// Loading schemes
`define MODE_PASSIVE_SERIAL 2'h0
`define MODE_FAST_PASSIVE_PARALLEL 2'h1
`define MODE_ACTIVE_SERIAL 2'h2
// Option bits of the first loaded byte
`define OPT_STARTUP_CLOCK 0
`define OPT_INIT_DONE 1
`define OPT_GLOBAL_OE 2
`define OPT_GLOBAL_CLEAR 3
// Timing counts
`define INIT_CYCLES 16'h0010
`define AS_HALF_PERIOD 8'h04
`endif

// [tb/config_host_model.sv]
`timescale 1ns/1ns
module config_host_model (
  input wire clkRef,
  input wire memClk,
  input wire memSelN,
  output logic hostClk,
  output logic [7:0] data
);
  logic memBits[$];
  bit seen;
  // Clock rests low outside frames
  initial
  begin
    hostClk = 1'b0;
    data = 8'h00;
  end
  // One bit or one byte per clock; spare pins keep changing
  // Edges move on system clock edges, 400 ns per link clock period
  task automatic send(input logic [7:0] b, input bit fast_passive_parallel);
    for (int i = 0; i < (fast_passive_parallel ? 1 : 8); i++)
    begin
      data <= fast_passive_parallel ? b : {~data[7:1], b[i]};
      repeat (4) @(posedge clkRef);
      hostClk <= 1'b1;
      repeat (4) @(posedge clkRef);
      hostClk <= 1'b0;
    end
    data <= ~data;
  endtask
  // Serial memory streams a bit per generated clock from select low
  always @(posedge memClk)
    seen = 1'b1;
  always @(negedge memSelN)
  begin
    seen = 1'b0;
    data[0] = memBits.pop_front();
  end
  always @(negedge memClk)
    if (!memSelN && seen && memBits.size() > 0)
    begin
      seen = 1'b0;
      data[0] = memBits.pop_front();
    end
  // Released line shows the inverse of its last value
  always @(posedge memSelN)
    data = ~data;
endmodule // config_host_model

// [tb/config_pin_interface_monitor.sv]
`timescale 1ns/1ns
module config_pin_interface_monitor (
  input wire clk_sys,
  input wire rst_n,
  input wire reconfigureRequestN,
  input wire configClockOut,
  input wire configClockOe,
  input wire [7:0] dataOe,
  input wire memorySelectN,
  input wire loadCompleteOe,
  input wire initDoneOe,
  input wire cfgByteValid,
  input wire userMode,
  input wire userClearN
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Generated clock edge while the memory is selected
  sequence s_edge;
    !memorySelectN && $changed(configClockOut);
  endsequence
  // Request held long enough to pass the synchroniser
  sequence s_req;
    !reconfigureRequestN [*5];
  endsequence
  a_select_clock: assert property
    (!memorySelectN |-> configClockOe) else $error("select without clock");
  a_half_period: assert property
    (s_edge |=> (memorySelectN || $stable(configClockOut)) [*2])
    else $error("clock half period short");
  a_user_release: assert property
    ($rose(userMode) |-> !initDoneOe) else $error("init-done held in user");
  a_done_released: assert property
    (userMode |-> !loadCompleteOe) else $error("load_complete held low");
  a_byte_pulse: assert property
    (cfgByteValid |-> !userMode ##1 !cfgByteValid)
    else $error("byte taken in user mode");
  a_pins_idle: assert property
    (dataOe != 8'h00 |-> userMode) else $error("pins driven in config");
  a_clear_config: assert property
    (!userMode |-> !userClearN) else $error("clear released early");
  a_reconfig_idle: assert property
    (s_req |-> !userMode && !initDoneOe) else $error("reconfigure ignored");
endmodule // config_pin_interface_monitor
bind config_pin_interface config_pin_interface_monitor mon (.*);

// [tb/test_config_pin_interface.sv]
`timescale 1ns/1ns
`include "config_pin_map.vh"
module test_config_pin_interface;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, configClockIn, configClockOut;
  logic configClockOe, memorySelectN, chipEnableN = 1'b0, e;
  logic doneWas = 1'b0;
  logic reconfigureRequestN = 1'b0, startupClockIn = 1'b0;
  logic globalOutputEnable = 1'b1, globalClearN = 1'b1, loadCompleteIn;
  logic loadCompleteOe, initDoneOe, optPullupEn, cfgByteValid, userMode;
  logic userClearN, userClockOut = 1'b0, userClockOe = 1'b0, hostClk;
  logic [7:0] paddr = 8'h00, dataIn, dataOut, dataOe, cfgByte, hostData;
  logic [7:0] userDataOut = 8'h00, userDataOe = 8'h00, exp[$], bytes[3];
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int bad_count = 0, compares = 0;
  config_pin_interface #(.INIT_COUNT(16'h0002)) DUT (.*);
  config_host_model host (
    .clkRef(clk_sys),
    .memClk(configClockIn),
    .memSelN(memorySelectN),
    .hostClk(hostClk),
    .data(hostData)
  );
  // Pin levels from every driver; pull-up on load_complete
  assign configClockIn = configClockOe ? configClockOut : hostClk;
  assign dataIn = (dataOe & dataOut) | (~dataOe & hostData);
  assign loadCompleteIn = ~loadCompleteOe;
  initial
    forever #25 clk_sys = ~clk_sys;
  // Free-running start-up clock, slower than the system clock
  initial
    forever
    begin
      repeat (5) @(posedge clk_sys);
      startupClockIn <= ~startupClockIn;
    end
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; result left in rd and e
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Load three bytes in one scheme, then check user mode
  task automatic run_mode(logic [1:0] m);
    int i;
    logic [3:0] o;
    logic [7:0] oeExp;
    reconfigureRequestN <= 1'b0;
    apb(1'b1, `REG_CTRL, {29'h0, 1'b1, m});
    apb(1'b1, `REG_LEN, 32'h3);
    o = (m == 2'h0) ? 4'h2 : {3'h7, m[1]};
    bytes[0] = {4'($urandom), o};
    bytes[1] = 8'($urandom);
    bytes[2] = 8'($urandom);
    for (i = 0; i < 24; i++)
      if (m == `MODE_ACTIVE_SERIAL)
        host.memBits.push_back(bytes[i / 8][i % 8]);
    foreach (bytes[i])
      exp.push_back(bytes[i]);
    repeat (4) @(posedge clk_sys);
    reconfigureRequestN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 3 && m != `MODE_ACTIVE_SERIAL; i++)
    begin
      host.send(bytes[i], m == `MODE_FAST_PASSIVE_PARALLEL);
      repeat (6) @(posedge clk_sys);
      if (i == 0) chk("initDoneOe", 1, initDoneOe);
      if (i == 0) chk("pullupsLoad", 1, optPullupEn);
    end
    for (i = 0; i < 3000 && userMode !== 1'b1; i++)
      @(posedge clk_sys);
    chk("userMode", 1, userMode);
    chk("userClearN", 1, userClearN);
    chk("clockOe", m[1], configClockOe);
    chk("clockOut", m[1] & userClockOut, configClockOut);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("status", {22'h0, 2'h3, o, 4'h3}, rd);
    apb(1'b0, `REG_COUNT, 32'h0);
    chk("count", 3, rd);
    oeExp = userDataOe & (m[1] ? 8'hfe : 8'hff);
    chk("dataOe", oeExp, dataOe);
    chk("dataOut", userDataOut, dataOut);
    chk("pullups", 0, optPullupEn);
    globalOutputEnable <= 1'b0;
    globalClearN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("dataOeOff", o[2] ? 8'h00 : oeExp, dataOe);
    chk("clearOn", !o[3], userClearN);
    globalOutputEnable <= 1'b1;
    globalClearN <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("clearOff", 1, userClearN);
    if (!m[1]) host.send(8'ha5, 1'b0);
    repeat (6) @(posedge clk_sys);
  endtask
  // Every loaded byte against the expected stream
  always @(posedge clk_sys)
    if (cfgByteValid === 1'b1)
      chk("cfgByte", exp.size() ? exp.pop_front() : 32'hx, cfgByte);
  // Init-done pin rising marks entry into user mode
  always @(posedge clk_sys)
  begin
    if (doneWas === 1'b1 && initDoneOe === 1'b0)
      chk("doneRise", 1, userMode);
    doneWas <= initDoneOe;
  end
  initial
  begin
    void'($urandom(32'h973ff46a));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    userDataOut <= 8'($urandom);
    userDataOe <= 8'($urandom) | 8'h81;
    userClockOut <= 1'($urandom);
    userClockOe <= 1'b1;
    for (int m = 0; m < 3; m++)
      run_mode(m[1:0]);
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 1, e);
    chk("unmapped", 0, rd);
    final_report;
  end
  initial
  begin
    #2000000;
    bad_count++;
    final_report;
  end
endmodule // test_config_pin_interface
